// ==== shared/phy_link_pkg.sv ====
// Purpose: Shared constants and types for the cable PHY link datapath
// Assumes: Core logic runs on a 250 MHz system clock
// Notes: Link clock is produced by phase-accumulator synthesis; bit rates are fixed per speed code
package phy_link_pkg;

    // Clock plan, all clock figures in kHz, then the port count
    localparam int SYS_CLK_KHZ = 250000;
    localparam int REF_CLK_KHZ = 98304;
    localparam int LINK_CLK_A_KHZ = 49152;
    localparam int LINK_CLK_B_KHZ = 98304;
    localparam int NUM_PORTS = 3;

    // Phase accumulator width and per-mode increments
    localparam int NCO_W = 24;
    localparam logic [NCO_W-1:0] NCO_INC_A =
        NCO_W'((longint'(LINK_CLK_A_KHZ) << NCO_W) / longint'(SYS_CLK_KHZ));
    localparam logic [NCO_W-1:0] NCO_INC_B =
        NCO_W'((longint'(LINK_CLK_B_KHZ) << NCO_W) / longint'(SYS_CLK_KHZ));

    // Serial bit rates in kbit/s
    localparam logic [19:0] RATE_S100_KBPS = 20'h18000;
    localparam logic [19:0] RATE_S200_KBPS = 20'h30000;
    localparam logic [19:0] RATE_S400_KBPS = 20'h60000;
    localparam logic [19:0] RATE_S400B_KBPS = 20'h78000;
    localparam logic [19:0] RATE_S800_KBPS = 20'hF0000;

    // Lane widths of the parallel link path
    localparam logic [3:0] LANES_2 = 4'h2;
    localparam logic [3:0] LANES_4 = 4'h4;
    localparam logic [3:0] LANES_8 = 4'h8;

    // Encoder scrambler seed for 1394b-signalling ports
    localparam logic [7:0] SCRAMBLE_SEED = 8'hA5;

    typedef enum logic [2:0] {
        SPD_S100 = 3'h0,
        SPD_S200 = 3'h1,
        SPD_S400 = 3'h2,
        SPD_S400B = 3'h3,
        SPD_S800 = 3'h4
    } speed_t;

    // One byte towards or from a cable port
    typedef struct packed {
        logic valid;
        logic beta;
        speed_t speed;
        logic [7:0] data;
    } port_tx_t;

    typedef struct packed {
        logic valid;
        speed_t speed;
        logic [7:0] data;
    } port_rx_t;

    // Bit rate of a speed code
    function automatic logic [19:0] rate_kbps(input speed_t s);
        logic [19:0] r;
        r = RATE_S100_KBPS;
        unique case (s)
            SPD_S100: r = RATE_S100_KBPS;
            SPD_S200: r = RATE_S200_KBPS;
            SPD_S400: r = RATE_S400_KBPS;
            SPD_S400B: r = RATE_S400B_KBPS;
            SPD_S800: r = RATE_S800_KBPS;
            default: r = RATE_S100_KBPS;
        endcase
        return r;
    endfunction

    // Link lanes used for a speed in a given interface mode
    function automatic logic [3:0] lane_width(input logic mode_b, input speed_t s);
        logic [3:0] w;
        w = LANES_8;
        if (!mode_b && s == SPD_S100) begin
            w = LANES_2;
        end else if (!mode_b && s == SPD_S200) begin
            w = LANES_4;
        end
        return w;
    endfunction

endpackage

// ==== design/link_clock_nco.sv ====
// Purpose: Phase-accumulator clock synthesis standing in for the PLL
// Assumes: Increment is chosen by the caller for the wanted frequency
// Notes: Stops with its output low while run is low
`timescale 1ns/1ns
module link_clock_nco
    import phy_link_pkg::*;
#(
    parameter int W = NCO_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [W-1:0] inc,
    output logic clk_level_q,
    output logic rise_q
);

    logic [W-1:0] acc_q;
    logic [W-1:0] acc_d;
    logic clk_level_d;
    logic rise_d;

    // Accumulate phase; the top bit is the synthesised clock
    always_comb begin
        acc_d = run ? W'(acc_q + inc) : '0;
        clk_level_d = run & acc_d[W-1];
        rise_d = clk_level_d & ~clk_level_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_q <= '0;
            clk_level_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            clk_level_q <= clk_level_d;
            rise_q <= rise_d;
        end
    end

endmodule // link_clock_nco

// ==== design/phy_link_datapath.sv ====
// Purpose: Link-side datapath and port signalling control of a 3-port PHY
// Assumes: Link controller runs on link_clk_q; cable logic on sys_clk
// Notes: Serial streams are carried as bytes with their speed and rate
// Function
// - select low gives legacy link interface
// - select high gives 1394b link interface
// - select low disables BOSS arbitration
// - select never chooses port signalling
// - legacy mode supplies 49.152 MHz link clock
// - 1394b mode supplies 98.304 MHz link clock
// - all timing derived from reference via PLL
// - power-down pin high halts PLL clocks
// - transmit path 2, 4 or 8 bits
// - 1394b mode path always 8 bits
// - latch, serialise, encode, send to ports
// - bit rate fixed per speed code
// - legacy peer gets data-strobe at S100-S400
// - 1394b peer gets S400B or S800
// - port signalling chosen from peer automatically
// - forced port never emits 1394b signalling
// - receive split into lanes, resynchronised
// - received data repeated on other ports
`timescale 1ns/1ns
module phy_link_datapath
    import phy_link_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_interface_select,
    input wire logic power_down_pin,
    input wire logic [NUM_PORTS-1:0] force_ds_pin,
    input wire logic [NUM_PORTS-1:0] peer_is_b_pin,
    input wire logic [NUM_PORTS-1:0] port_active_pin,
    input wire logic [7:0] link_tx_data,
    input wire logic link_tx_valid,
    input wire speed_t link_tx_speed,
    input wire port_rx_t [NUM_PORTS-1:0] port_rx,
    output logic link_clk_q,
    output logic [7:0] link_rx_data_q,
    output logic link_rx_valid_q,
    output speed_t link_rx_speed_q,
    output logic boss_enable_q,
    output logic pll_running_q,
    output port_tx_t [NUM_PORTS-1:0] port_tx_q,
    output logic [NUM_PORTS-1:0][19:0] port_rate_q
);

    // Pin synchronisers; stage one feeds only stage two
    logic sel_s1_q, sel_s2_q, powerdown_s1_q, powerdown_s2_q;
    logic [NUM_PORTS-1:0] fds_s1_q, fds_s2_q, peer_s1_q, peer_s2_q;
    logic [NUM_PORTS-1:0] act_s1_q, act_s2_q;

    // Strap synchroniser keeps sampling through reset so the strap is settled at release
    always_ff @(posedge sys_clk) begin
        sel_s1_q <= link_interface_select;
        sel_s2_q <= sel_s1_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            powerdown_s1_q <= 1'b1;
            powerdown_s2_q <= 1'b1;
            fds_s1_q <= '1;
            fds_s2_q <= '1;
            peer_s1_q <= '0;
            peer_s2_q <= '0;
            act_s1_q <= '0;
            act_s2_q <= '0;
        end else begin
            powerdown_s1_q <= power_down_pin;
            powerdown_s2_q <= powerdown_s1_q;
            fds_s1_q <= force_ds_pin;
            fds_s2_q <= fds_s1_q;
            peer_s1_q <= peer_is_b_pin;
            peer_s2_q <= peer_s1_q;
            act_s1_q <= port_active_pin;
            act_s2_q <= act_s1_q;
        end
    end

    // Mode strap, caught once after reset release, and PLL run control
    logic mode_b_q, mode_b_d, strap_taken_q, strap_taken_d, boss_enable_d, pll_run_d;

    always_comb begin
        strap_taken_d = 1'b1;
        mode_b_d = strap_taken_q ? mode_b_q : sel_s2_q;
        boss_enable_d = mode_b_d;
        pll_run_d = ~powerdown_s2_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_taken_q <= 1'b0;
            mode_b_q <= 1'b0;
            boss_enable_q <= 1'b0;
            pll_running_q <= 1'b0;
        end else begin
            strap_taken_q <= strap_taken_d;
            mode_b_q <= mode_b_d;
            boss_enable_q <= boss_enable_d;
            pll_running_q <= pll_run_d;
        end
    end

    // Link clock synthesised from the core reference; rate follows mode
    logic nco_level, link_rise;

    link_clock_nco #(.W(NCO_W)) u_link_nco (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(pll_running_q),
        .inc(mode_b_q ? NCO_INC_B : NCO_INC_A),
        .clk_level_q(nco_level),
        .rise_q(link_rise)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            link_clk_q <= 1'b0;
        end else begin
            link_clk_q <= nco_level;
        end
    end

    // Transmit packer: gathers link lanes into whole bytes
    logic [7:0] tx_acc_q, tx_acc_d, tx_byte_q, tx_byte_d;
    logic [2:0] tx_cnt_q, tx_cnt_d;
    logic tx_done_q, tx_done_d;
    speed_t tx_spd_q, tx_spd_d;
    logic [3:0] tx_lanes;

    always_comb begin
        tx_lanes = lane_width(mode_b_q, link_tx_speed);
        tx_acc_d = tx_acc_q;
        tx_cnt_d = tx_cnt_q;
        tx_byte_d = tx_byte_q;
        tx_spd_d = tx_spd_q;
        tx_done_d = 1'b0;
        if (link_rise && link_tx_valid) begin
            tx_acc_d = 8'(tx_acc_q << tx_lanes) | (link_tx_data & 8'(8'hFF >> (4'h8 - tx_lanes)));
            tx_cnt_d = 3'(tx_cnt_q + 3'h1);
            if ({1'b0, tx_cnt_d} == 4'(4'h8 / tx_lanes)) begin
                tx_byte_d = tx_acc_d;
                tx_spd_d = link_tx_speed;
                tx_done_d = 1'b1;
                tx_cnt_d = 3'h0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tx_acc_q <= 8'h00;
            tx_cnt_q <= 3'h0;
            tx_byte_q <= 8'h00;
            tx_spd_q <= SPD_S100;
            tx_done_q <= 1'b0;
        end else begin
            tx_acc_q <= tx_acc_d;
            tx_cnt_q <= tx_cnt_d;
            tx_byte_q <= tx_byte_d;
            tx_spd_q <= tx_spd_d;
            tx_done_q <= tx_done_d;
        end
    end

    // Receive pick: lowest active port with a byte is the source
    logic rx_hit;
    logic [1:0] rx_src;
    port_rx_t rx_sel;

    always_comb begin
        rx_hit = 1'b0;
        rx_src = 2'h0;
        rx_sel = '0;
        for (int i = NUM_PORTS - 1; i >= 0; i--) begin
            if (port_rx[i].valid && act_s2_q[i] && pll_running_q) begin
                rx_hit = 1'b1;
                rx_src = 2'(i);
                rx_sel = port_rx[i];
            end
        end
    end

    // Receive splitter: hands bytes to the link lane-group by lane-group
    logic [7:0] rx_hold_q, rx_hold_d, rx_out_d;
    logic [2:0] rx_left_q, rx_left_d;
    speed_t rx_spd_q, rx_spd_d;
    logic rx_out_v_d;
    logic [3:0] rx_lanes;

    always_comb begin
        rx_hold_d = rx_hold_q;
        rx_left_d = rx_left_q;
        rx_spd_d = rx_spd_q;
        rx_out_d = link_rx_data_q;
        rx_out_v_d = link_rx_valid_q;
        rx_lanes = lane_width(mode_b_q, rx_spd_q);
        if (rx_left_q == 3'h0 && rx_hit) begin
            rx_hold_d = rx_sel.data;
            rx_spd_d = rx_sel.speed;
            rx_left_d = 3'(4'h8 / lane_width(mode_b_q, rx_sel.speed));
        end
        if (link_rise) begin
            rx_out_v_d = rx_left_q != 3'h0;
            rx_out_d = 8'h00;
            if (rx_left_q != 3'h0) begin
                rx_out_d = 8'(rx_hold_q >> (4'h8 - rx_lanes));
                rx_hold_d = 8'(rx_hold_q << rx_lanes);
                rx_left_d = 3'(rx_left_q - 3'h1);
            end
        end
        if (!pll_running_q) begin
            rx_out_v_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rx_hold_q <= 8'h00;
            rx_left_q <= 3'h0;
            rx_spd_q <= SPD_S100;
            link_rx_data_q <= 8'h00;
            link_rx_valid_q <= 1'b0;
            link_rx_speed_q <= SPD_S100;
        end else begin
            rx_hold_q <= rx_hold_d;
            rx_left_q <= rx_left_d;
            rx_spd_q <= rx_spd_d;
            link_rx_data_q <= rx_out_d;
            link_rx_valid_q <= rx_out_v_d;
            link_rx_speed_q <= rx_spd_q;
        end
    end

    // Encoder scrambler, advanced once per byte sent out
    logic [7:0] scr_q, scr_d;
    logic src_valid;
    logic [7:0] src_data;
    speed_t src_spd;

    always_comb begin
        src_valid = (rx_hit || tx_done_q) && pll_running_q;
        src_data = rx_hit ? rx_sel.data : tx_byte_q;
        src_spd = rx_hit ? rx_sel.speed : tx_spd_q;
        scr_d = src_valid ? {scr_q[6:0], scr_q[7] ^ scr_q[5] ^ scr_q[4] ^ scr_q[3]} : scr_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scr_q <= SCRAMBLE_SEED;
        end else begin
            scr_q <= scr_d;
        end
    end

    // Per-port signalling choice, speed fit and byte output
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        port_tx_t tx_d;
        logic [19:0] rate_d;
        logic beta;

        always_comb begin
            beta = peer_s2_q[p] & ~fds_s2_q[p];
            tx_d = '0;
            tx_d.beta = beta;
            if (beta) begin
                tx_d.speed = (src_spd == SPD_S800) ? SPD_S800 : SPD_S400B;
            end else begin
                tx_d.speed = (src_spd > SPD_S400) ? SPD_S400 : src_spd;
            end
            tx_d.valid = src_valid && act_s2_q[p] && !(rx_hit && rx_src == 2'(p));
            tx_d.data = beta ? (src_data ^ scr_q) : src_data;
            rate_d = rate_kbps(tx_d.speed);
        end

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                port_tx_q[p] <= '0;
                port_rate_q[p] <= RATE_S100_KBPS;
            end else begin
                port_tx_q[p] <= tx_d;
                port_rate_q[p] <= rate_d;
            end
        end
    end

    // Checks on the datapath
    a_boss_follows_mode: assert property (@(posedge sys_clk) disable iff (rst)
        strap_taken_q |-> ##1 (boss_enable_q == $past(mode_b_q)))
        else $error("BOSS enable does not follow interface mode");
    a_powerdown_stops_clock: assert property (@(posedge sys_clk) disable iff (rst)
        powerdown_s2_q [*3] |=> !link_clk_q && !link_rise)
        else $error("Link clock runs while powered down");
    a_clock_rate_a: assert property (@(posedge sys_clk)
        disable iff (rst || !pll_running_q || mode_b_q)
        link_rise |=> !link_rise [*4] ##[1:2] link_rise)
        else $error("Legacy link clock rate wrong");
    a_clock_rate_b: assert property (@(posedge sys_clk)
        disable iff (rst || !pll_running_q || !mode_b_q)
        link_rise |=> !link_rise ##[1:2] link_rise)
        else $error("1394b link clock rate wrong");
    a_forced_no_beta: assert property (@(posedge sys_clk) disable iff (rst)
        fds_s2_q[2] |=> !port_tx_q[2].beta)
        else $error("Forced port shows 1394b signalling");
    a_beta_speed_fit: assert property (@(posedge sys_clk) disable iff (rst)
        port_tx_q[0].beta |-> port_tx_q[0].speed inside {SPD_S400B, SPD_S800})
        else $error("1394b port at legacy speed");
    a_ds_speed_fit: assert property (@(posedge sys_clk) disable iff (rst)
        !port_tx_q[2].beta |-> port_tx_q[2].speed <= SPD_S400)
        else $error("Data-strobe port above S400");
    a_repeat_others: assert property (@(posedge sys_clk) disable iff (rst)
        (rx_hit && rx_src == 2'h0 && act_s2_q[1]) |=> port_tx_q[1].valid && !port_tx_q[0].valid)
        else $error("Received byte not repeated correctly");
    a_tx_reaches_port: assert property (@(posedge sys_clk) disable iff (rst)
        (tx_done_q && !rx_hit && pll_running_q && act_s2_q[1]) |=>
        port_tx_q[1].valid && (port_tx_q[1].beta || port_tx_q[1].data == $past(tx_byte_q)))
        else $error("Packed byte not sent to port");
    a_rx_b_width: assert property (@(posedge sys_clk) disable iff (rst)
        (mode_b_q && rx_left_q == 3'h0 && rx_hit) |=> rx_left_q == 3'h1)
        else $error("1394b mode receive not byte wide");

endmodule // phy_link_datapath

// ==== testbench/link_ctrl_model.sv ====
// Purpose: Link controller model on the parallel PHY-link side
// Assumes: Lanes change 1 ns after a link clock rise
// Notes: Received lane groups are queued for the bench to judge
`timescale 1ns/1ns
module link_ctrl_model
    import phy_link_pkg::*;
(
    input wire logic sys_clk,
    input wire logic link_clk,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output speed_t tx_speed
);
    logic [7:0] rx_q[$];
    logic lk_prev;

    // Lanes idle until a byte is sent
    initial begin
        tx_data = 8'h00;
        tx_valid = 1'b0;
        tx_speed = SPD_S100;
    end

    // One lane group per link clock, MSB group first, held a full period
    task automatic send_byte(input logic [7:0] d, input speed_t s, input logic mode_b);
        logic [3:0] w;
        w = (!mode_b && s == SPD_S100) ? 4'h2 : (!mode_b && s == SPD_S200) ? 4'h4 : 4'h8;
        for (int g = 0; g < 8 / w; g++) begin
            @(posedge link_clk);
            #1;
            tx_valid = 1'b1;
            tx_speed = s;
            tx_data = 8'((d >> (8 - w * (g + 1))) & ((1 << w) - 1));
        end
        @(posedge link_clk);
        #1;
        tx_valid = 1'b0;
        tx_data = ~tx_data; // Released lanes must not look like the last group
    endtask

    // Take a group just after the link clock falls, well clear of updates
    always @(posedge sys_clk) begin
        if (lk_prev && !link_clk && rx_valid) begin
            rx_q.push_back(rx_data);
        end
        lk_prev <= link_clk;
    end
endmodule // link_ctrl_model

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the PHY link datapath
// Assumes: Port 0 peer is 1394b, port 1 legacy, port 2 forced to data-strobe
// Notes: Runs both strap modes, each after its own reset
`timescale 1ns/1ns
module tb_top
    import phy_link_pkg::*;
;
    logic sys_clk;
    logic rst;
    logic sel;
    logic power_down;
    logic [NUM_PORTS-1:0] force_ds;
    logic [NUM_PORTS-1:0] peer_b;
    logic [NUM_PORTS-1:0] active;
    logic [7:0] tx_data;
    logic tx_valid;
    speed_t tx_speed;
    port_rx_t [NUM_PORTS-1:0] port_rx;
    logic link_clk_q;
    logic [7:0] link_rx_data_q;
    logic link_rx_valid_q;
    speed_t link_rx_speed_q;
    logic boss_enable_q;
    logic pll_running_q;
    port_tx_t [NUM_PORTS-1:0] port_tx_q;
    logic [NUM_PORTS-1:0][19:0] port_rate_q;
    int n_errors = 0;
    int total_checks = 0;
    int n_rise;
    int tx_cnt[NUM_PORTS];
    port_tx_t tx_last[NUM_PORTS];
    logic lk_prev;

    phy_link_datapath u_phy_link_datapath (
        .sys_clk(sys_clk), .rst(rst), .link_interface_select(sel), .power_down_pin(power_down),
        .force_ds_pin(force_ds), .peer_is_b_pin(peer_b), .port_active_pin(active),
        .link_tx_data(tx_data), .link_tx_valid(tx_valid), .link_tx_speed(tx_speed),
        .port_rx(port_rx), .link_clk_q(link_clk_q), .link_rx_data_q(link_rx_data_q),
        .link_rx_valid_q(link_rx_valid_q), .link_rx_speed_q(link_rx_speed_q),
        .boss_enable_q(boss_enable_q), .pll_running_q(pll_running_q),
        .port_tx_q(port_tx_q), .port_rate_q(port_rate_q)
    );

    link_ctrl_model u_link_ctrl_model (
        .sys_clk(sys_clk), .link_clk(link_clk_q), .rx_data(link_rx_data_q),
        .rx_valid(link_rx_valid_q), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_speed(tx_speed)
    );

    always #2 sys_clk = ~sys_clk;

    // Count link clock rises and catch each outgoing port byte
    always @(posedge sys_clk) begin
        lk_prev <= link_clk_q;
        if (link_clk_q && !lk_prev) begin
            n_rise++;
        end
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (port_tx_q[i].valid) begin
                tx_cnt[i]++;
                tx_last[i] = port_tx_q[i];
            end
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [19:0] rate_of(input speed_t s);
        case (s)
            SPD_S100: return RATE_S100_KBPS;
            SPD_S200: return RATE_S200_KBPS;
            SPD_S400: return RATE_S400_KBPS;
            SPD_S400B: return RATE_S400B_KBPS;
            default: return RATE_S800_KBPS;
        endcase
    endfunction

    // Bounded wait for the clock-running flag
    task automatic wait_pll(input logic v);
        int k;
        k = 0;
        while (pll_running_q !== v && k < 50) begin
            cyc(1);
            k++;
        end
        chk(pll_running_q, v);
    endtask

    // Reset with the strap set, checking outputs while reset is held
    task automatic do_reset(input logic mode);
        rst = 1'b1;
        sel = mode;
        cyc(3);
        for (int i = 0; i < NUM_PORTS; i++) begin
            chk({port_tx_q[i].valid, port_rate_q[i]}, RATE_S100_KBPS);
        end
        chk({link_clk_q, boss_enable_q, pll_running_q, link_rx_valid_q}, 0);
        cyc(1);
        rst = 1'b0;
        wait_pll(1'b1);
        cyc(20);
    endtask

    // Link clock rate and arbitration permission for the strapped mode
    task automatic t_mode(input logic mode);
        int exp;
        exp = (mode ? LINK_CLK_B_KHZ : LINK_CLK_A_KHZ) * 1000 / SYS_CLK_KHZ;
        n_rise = 0;
        cyc(1000);
        chk(n_rise >= exp - 1 && n_rise <= exp + 2, 1);
        chk(boss_enable_q, mode);
    endtask

    // Power-down stops the link clock; release brings it back
    task automatic t_power_down();
        power_down = 1'b1;
        wait_pll(1'b0);
        cyc(5);
        n_rise = 0;
        cyc(100);
        chk({n_rise, link_clk_q}, 0);
        power_down = 1'b0;
        wait_pll(1'b1);
        cyc(20);
    endtask

    // Every speed code through the lanes; signalling chosen per port
    task automatic t_tx_speeds(input logic mode);
        speed_t s;
        speed_t ds;
        speed_t bs;
        for (int k = 0; k < 5; k++) begin
            s = speed_t'(k);
            ds = (s > SPD_S400) ? SPD_S400 : s;
            bs = (s == SPD_S800) ? SPD_S800 : SPD_S400B;
            tx_cnt = '{0, 0, 0};
            u_link_ctrl_model.send_byte(8'hC3, s, mode);
            cyc(12);
            chk(tx_cnt[1], 1);
            chk(tx_last[1].data, 8'hC3);
            chk({tx_last[1].beta, tx_last[1].speed}, {1'b0, ds});
            chk(port_rate_q[1], rate_of(ds));
            chk({tx_last[0].beta, tx_last[0].speed}, {1'b1, bs});
            chk(port_rate_q[0], rate_of(bs));
            chk(tx_last[2].beta, 1'b0);
        end
    endtask

    // One received byte: lane groups to the link, repeats to other ports
    task automatic t_rx(input logic mode);
        logic [7:0] exp_q[$];
        speed_t s;
        s = mode ? SPD_S800 : SPD_S100;
        if (mode) begin
            exp_q = '{8'hA5};
        end else begin
            exp_q = '{8'h02, 8'h02, 8'h01, 8'h01};
        end
        u_link_ctrl_model.rx_q.delete();
        tx_cnt = '{0, 0, 0};
        port_rx[0] = '{valid: 1'b1, speed: s, data: 8'hA5};
        cyc(1);
        port_rx[0] = '{valid: 1'b0, speed: SPD_S100, data: 8'h5A};
        cyc(40);
        chk(u_link_ctrl_model.rx_q.size(), exp_q.size());
        foreach (exp_q[i]) begin
            chk(u_link_ctrl_model.rx_q[i], exp_q[i]);
        end
        chk(link_rx_speed_q, s);
        chk(tx_cnt[0], 0);
        chk(tx_cnt[1], 1);
        chk(tx_cnt[2], 1);
        chk(tx_last[1].data, 8'hA5);
    endtask

    // An inactive port gets no outgoing bytes
    task automatic t_inactive();
        active = 3'b011;
        cyc(5);
        tx_cnt = '{0, 0, 0};
        u_link_ctrl_model.send_byte(8'h3C, SPD_S400, 1'b1);
        cyc(12);
        chk(tx_cnt[2], 0);
        chk(tx_cnt[1], 1);
    endtask

    // Main sequence, legacy strap first then 1394b strap
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        sel = 1'b0;
        power_down = 1'b0;
        force_ds = 3'b100;
        peer_b = 3'b101;
        active = 3'b111;
        port_rx = '0;
        do_reset(1'b0);
        t_mode(1'b0);
        t_tx_speeds(1'b0);
        t_rx(1'b0);
        t_power_down();
        do_reset(1'b1);
        t_mode(1'b1);
        t_tx_speeds(1'b1);
        t_rx(1'b1);
        t_inactive();
        test_done();
    end

    // Watchdog: the sequence needs about 2500 cycles, allow ten times that
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule // tb_top
